// ==== vdsr_regs.vh ====
`ifndef VDSR_REGS_VH
`define VDSR_REGS_VH

`define VDSR_ADDR_SILICON_REVISION   8'h80
`define VDSR_ADDR_LOCK_STANDARD      8'h81
`define VDSR_ADDR_SOURCE_DETECT      8'h82
`define VDSR_ADDR_NOISE_ESTIMATE     8'h83
`define VDSR_ADDR_SLICER_LINE_ID     8'h84
`define VDSR_ADDR_SLICER_FILTER      8'h85
`define VDSR_ADDR_INTERRUPT_ACK_A    8'h7E
`define VDSR_ADDR_INTERRUPT_ACK_B    8'h7F

`define VDSR_UNMAPPED_DATA           8'h00

`define VDSR_BIT_VSYNC_MARGINAL      7
`define VDSR_BIT_BLANK_SHIFT         6
`define VDSR_BIT_INTERLACE           5
`define VDSR_BIT_DISC_SOURCE         4
`define VDSR_BIT_TAPE_SOURCE         3
`define VDSR_BIT_OVERLAY_INSERT      2
`define VDSR_BIT_FAST_BLANK          1
`define VDSR_BIT_LINE_COUNT          0

`define VDSR_LINES_50_MIN            10'd310
`define VDSR_LINES_50_MAX            10'd314
`define VDSR_LINES_60_MIN            10'd260
`define VDSR_LINES_60_MAX            10'd264

`define VDSR_PCT_SCALE               7'd100
`define VDSR_PCT_PARITY_LO           7'd25
`define VDSR_PCT_PARITY_HI           7'd75
`define VDSR_PCT_BAND1_LO            7'd20
`define VDSR_PCT_BAND1_HI            7'd30
`define VDSR_PCT_BAND2_LO            7'd70
`define VDSR_PCT_BAND2_HI            7'd80

`endif

// ==== vdsr_vsync_pos.v ====
`timescale 1ns/1ps
`default_nettype none

module vdsr_vsync_pos
#(
	parameter CW = 12
)
(
	input  wire          clk,
	input  wire          rst,
	input  wire          hsync_pulse,
	input  wire          vsync_pulse,
	output reg           field_end_reg,
	output reg           parity_reg,
	output reg           marginal_reg
);

`include "vdsr_regs.vh"

	reg [CW-1:0] count_reg;
	reg [CW-1:0] len_reg;
	wire [CW+6:0] pos_scaled;

	// len * pct at full product width, so no threshold wraps
	function [CW+6:0] pct_of;
		input [CW-1:0] len;
		input [6:0]    pct;
		begin
			pct_of = {7'd0, len} * {{CW{1'b0}}, pct};
		end
	endfunction

	// true when pos*100 lies in [len*lo, len*hi]
	function in_band;
		input [CW+6:0] pos_x;
		input [CW-1:0] len;
		input [6:0]    lo;
		input [6:0]    hi;
		begin
			in_band = (pos_x >= pct_of(len, lo)) && (pos_x <= pct_of(len, hi));
		end
	endfunction

	assign pos_scaled = pct_of(count_reg, `VDSR_PCT_SCALE);

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg     <= {CW{1'b0}};
			len_reg       <= {CW{1'b0}};
			field_end_reg <= 1'b0;
			parity_reg    <= 1'b0;
			marginal_reg  <= 1'b0;
		end
		else
		begin
			field_end_reg <= vsync_pulse;
			if (hsync_pulse)
			begin
				// restart at 1 so count and length both equal clocks since hsync
				count_reg <= {{(CW-1){1'b0}}, 1'b1};
				len_reg   <= count_reg;
			end
			else if (count_reg != {CW{1'b1}})
				count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
			if (vsync_pulse)
			begin
				// mid-line vsync marks the second field
				parity_reg   <= (pos_scaled >= pct_of(len_reg, `VDSR_PCT_PARITY_LO)) &&
					(pos_scaled < pct_of(len_reg, `VDSR_PCT_PARITY_HI));
				marginal_reg <= in_band(pos_scaled, len_reg, `VDSR_PCT_BAND1_LO, `VDSR_PCT_BAND1_HI) ||
					in_band(pos_scaled, len_reg, `VDSR_PCT_BAND2_LO, `VDSR_PCT_BAND2_HI);
			end
		end
	end

endmodule

`default_nettype wire

// ==== vdsr_status.v ====
`timescale 1ns/1ps
`default_nettype none

module vdsr_status
#(
	// revision nibble defaults are arbitrary
	parameter [3:0] FULL_LAYER_CUT   = 4'h3,
	parameter [3:0] METAL_FIX_CUT    = 4'h0,
	parameter [7:0] SHIFT_THRESHOLD  = 8'h10,
	parameter [7:0] LOW_NOISE_LIMIT  = 8'h20,
	parameter       LINE_CW          = 12
)
(
	input  wire       clk,
	input  wire       rst,
	input  wire [7:0] reg_addr,
	input  wire       reg_rd,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata_reg,
	input  wire       vert_sync_captured,
	input  wire       horiz_pll_locked,
	input  wire       output_pll_locked,
	input  wire       field_rate_is_fifty,
	input  wire       standard_identified,
	input  wire [2:0] identified_standard_code,
	input  wire       disc_player_source_seen,
	input  wire       tape_source_seen,
	input  wire [7:0] noise_estimate_value,
	input  wire [5:0] slicer_line_select,
	input  wire [7:0] slicer_filter_value,
	input  wire       hsync_pulse,
	input  wire       vsync_pulse,
	input  wire       active_line,
	input  wire       in_vbi,
	input  wire [7:0] blank_shift_amount,
	input  wire       fast_blank,
	output reg        field_parity_reg,
	output reg        irq_reg
);

`include "vdsr_regs.vh"

	localparam NSRC = 10;

	// lock/standard byte and disc/tape source bits, sampled every clock
	reg  [7:0]      lock_standard_reg;
	reg             disc_reg;
	reg             tape_reg;
	reg  [7:0]      noise_reg;
	reg  [7:0]      line_id_echo_reg;
	reg  [7:0]      slicer_filter_reg;

	// fast-blank pin comes from outside the clock domain
	reg             fb_meta_reg;
	reg             fb_sync_reg;
	reg             fb_prev_reg;

	reg             fb_acc_reg;
	reg             ins_acc_reg;
	reg             shift_acc_reg;
	reg             fast_blank_seen_reg;
	reg             overlay_insert_seen_reg;
	reg             blank_shift_seen_reg;

	reg  [9:0]      lines_reg;
	reg             line_count_bad_reg;
	reg             interlace_reg;
	reg             last_parity_reg;
	reg             have_parity_reg;

	reg  [7:0]      ack_a_reg;
	reg  [1:0]      ack_b_reg;
	reg  [NSRC-1:0] watch_prev_reg;
	reg  [NSRC-1:0] pending_reg;
	reg  [NSRC-1:0] pending_next;

	wire            vp_field_end;
	wire            vp_parity;
	wire            vp_marginal;
	wire [7:0]      source_detect;
	wire [NSRC-1:0] watch;
	wire [NSRC-1:0] ack_hit;
	wire            fb_event;
	wire            ins_event;
	wire            shift_event;
	wire            fifty;
	wire [9:0]      lines_done;

	function xor6;
		input [5:0] v;
		begin
			xor6 = ^v;
		end
	endfunction

	function in_limits;
		input [9:0] n;
		input [9:0] lo;
		input [9:0] hi;
		begin
			in_limits = (n >= lo) && (n <= hi);
		end
	endfunction

	vdsr_vsync_pos
	#(
		.CW (LINE_CW)
	)
	u_vpos
	(
		.clk           (clk),
		.rst           (rst),
		.hsync_pulse   (hsync_pulse),
		.vsync_pulse   (vsync_pulse),
		.field_end_reg (vp_field_end),
		.parity_reg    (vp_parity),
		.marginal_reg  (vp_marginal)
	);

	assign fifty       = lock_standard_reg[4];
	assign fb_event    = fb_sync_reg;
	assign ins_event   = active_line && (fb_sync_reg != fb_prev_reg);
	assign shift_event = in_vbi && (blank_shift_amount > SHIFT_THRESHOLD) &&
		(noise_estimate_value < LOW_NOISE_LIMIT);
	assign lines_done  = lines_reg + {9'd0, hsync_pulse};

	assign source_detect = {
		vp_marginal,
		blank_shift_seen_reg,
		interlace_reg,
		disc_reg,
		tape_reg,
		overlay_insert_seen_reg,
		fast_blank_seen_reg,
		line_count_bad_reg
	};

	// ack A bits 7..0 then ack B bits 1..0
	assign watch = {
		interlace_reg,
		tape_reg,
		overlay_insert_seen_reg,
		fast_blank_seen_reg,
		lock_standard_reg[5],
		lock_standard_reg[7],
		lock_standard_reg[6],
		lock_standard_reg[3],
		vp_marginal,
		line_count_bad_reg
	};
	assign ack_hit = {ack_a_reg, ack_b_reg};

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lock_standard_reg <= 8'h00;
			disc_reg          <= 1'b0;
			tape_reg          <= 1'b0;
			noise_reg         <= 8'h00;
			line_id_echo_reg  <= 8'h00;
			slicer_filter_reg <= 8'h00;
		end
		else
		begin
			lock_standard_reg <= {
				vert_sync_captured,
				horiz_pll_locked,
				output_pll_locked,
				field_rate_is_fifty,
				standard_identified,
				identified_standard_code
			};
			disc_reg          <= disc_player_source_seen;
			tape_reg          <= tape_source_seen;
			noise_reg         <= noise_estimate_value;
			// bit 6 parity of the id, bit 7 checksum of odd positions
			line_id_echo_reg  <= {xor6({slicer_line_select[5], 1'b0, slicer_line_select[3], 1'b0,
				slicer_line_select[1], 1'b0}), xor6(slicer_line_select), slicer_line_select};
			slicer_filter_reg <= slicer_filter_value;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fb_meta_reg <= 1'b0;
			fb_sync_reg <= 1'b0;
			fb_prev_reg <= 1'b0;
		end
		else
		begin
			fb_meta_reg <= fast_blank;
			fb_sync_reg <= fb_meta_reg;
			fb_prev_reg <= fb_sync_reg;
		end
	end

	// per-field accumulation, published at vsync and held for the next field
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fb_acc_reg              <= 1'b0;
			ins_acc_reg             <= 1'b0;
			shift_acc_reg           <= 1'b0;
			fast_blank_seen_reg     <= 1'b0;
			overlay_insert_seen_reg <= 1'b0;
			blank_shift_seen_reg    <= 1'b0;
		end
		else if (vsync_pulse)
		begin
			fast_blank_seen_reg     <= fb_acc_reg | fb_event;
			overlay_insert_seen_reg <= ins_acc_reg | ins_event;
			blank_shift_seen_reg    <= shift_acc_reg | shift_event;
			// events in the boundary cycle are kept, not dropped
			fb_acc_reg              <= 1'b0;
			ins_acc_reg             <= 1'b0;
			shift_acc_reg           <= 1'b0;
		end
		else
		begin
			fb_acc_reg    <= fb_acc_reg | fb_event;
			ins_acc_reg   <= ins_acc_reg | ins_event;
			shift_acc_reg <= shift_acc_reg | shift_event;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lines_reg          <= 10'd0;
			line_count_bad_reg <= 1'b0;
		end
		else if (vsync_pulse)
		begin
			lines_reg <= 10'd0;
			if (fifty)
				line_count_bad_reg <= !in_limits(lines_done, `VDSR_LINES_50_MIN, `VDSR_LINES_50_MAX);
			else
				line_count_bad_reg <= !in_limits(lines_done, `VDSR_LINES_60_MIN, `VDSR_LINES_60_MAX);
		end
		else if (hsync_pulse && lines_reg != 10'h3FF)
			lines_reg <= lines_reg + 10'd1;
	end

	// alternating parity from field to field means interlaced input
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			interlace_reg    <= 1'b0;
			last_parity_reg  <= 1'b0;
			have_parity_reg  <= 1'b0;
			field_parity_reg <= 1'b0;
		end
		else if (vp_field_end)
		begin
			interlace_reg    <= have_parity_reg && (vp_parity != last_parity_reg);
			last_parity_reg  <= vp_parity;
			have_parity_reg  <= 1'b1;
			field_parity_reg <= vp_parity;
		end
	end

	always @*
	begin
		// set wins over a same-cycle acknowledge
		pending_next = (pending_reg & ~ack_hit) | (watch ^ watch_prev_reg);
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ack_a_reg      <= 8'h00;
			ack_b_reg      <= 2'h0;
			watch_prev_reg <= {NSRC{1'b0}};
			pending_reg    <= {NSRC{1'b0}};
			irq_reg        <= 1'b0;
		end
		else
		begin
			// ack bits live exactly one clock after being written high
			ack_a_reg      <= (reg_wr && reg_addr == `VDSR_ADDR_INTERRUPT_ACK_A) ? reg_wdata : 8'h00;
			ack_b_reg      <= (reg_wr && reg_addr == `VDSR_ADDR_INTERRUPT_ACK_B) ? reg_wdata[1:0] : 2'h0;
			watch_prev_reg <= watch;
			pending_reg    <= pending_next;
			irq_reg        <= |pending_next;
		end
	end

	// read path has no side effects; writes to status addresses are ignored
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			reg_rdata_reg <= `VDSR_UNMAPPED_DATA;
		else if (reg_rd)
		begin
			case (reg_addr)
				`VDSR_ADDR_SILICON_REVISION: reg_rdata_reg <= {FULL_LAYER_CUT, METAL_FIX_CUT};
				`VDSR_ADDR_LOCK_STANDARD:    reg_rdata_reg <= lock_standard_reg;
				`VDSR_ADDR_SOURCE_DETECT:    reg_rdata_reg <= source_detect;
				`VDSR_ADDR_NOISE_ESTIMATE:   reg_rdata_reg <= noise_reg;
				`VDSR_ADDR_SLICER_LINE_ID:   reg_rdata_reg <= line_id_echo_reg;
				`VDSR_ADDR_SLICER_FILTER:    reg_rdata_reg <= slicer_filter_reg;
				default:                     reg_rdata_reg <= `VDSR_UNMAPPED_DATA;
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== vdsr_status_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module vdsr_status_monitor
#(
	// revision nibble defaults are arbitrary
	parameter [3:0] FULL_LAYER_CUT = 4'h3,
	parameter [3:0] METAL_FIX_CUT  = 4'h0
)
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata_reg,
	input wire logic       vert_sync_captured,
	input wire logic       horiz_pll_locked,
	input wire logic       output_pll_locked,
	input wire logic       field_rate_is_fifty,
	input wire logic       standard_identified,
	input wire logic [2:0] identified_standard_code,
	input wire logic       disc_player_source_seen,
	input wire logic       tape_source_seen,
	input wire logic [7:0] noise_estimate_value,
	input wire logic [5:0] slicer_line_select,
	input wire logic       irq_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rev_read_a: assert property (reg_rd && reg_addr == 8'h80
		|=> reg_rdata_reg == {FULL_LAYER_CUT, METAL_FIX_CUT}) else $error("revision read wrong");
	lock_read_a: assert property (reg_rd && reg_addr == 8'h81
		|=> reg_rdata_reg[7:5] == $past({vert_sync_captured, horiz_pll_locked, output_pll_locked}, 2))
		else $error("lock flags read wrong");
	std_read_a: assert property (reg_rd && reg_addr == 8'h81
		|=> reg_rdata_reg[4:0] == $past({field_rate_is_fifty, standard_identified, identified_standard_code}, 2))
		else $error("standard fields read wrong");
	noise_read_a: assert property (reg_rd && reg_addr == 8'h83
		|=> reg_rdata_reg == $past(noise_estimate_value, 2)) else $error("noise read wrong");
	slicer_echo_a: assert property (reg_rd && reg_addr == 8'h84 |=>
		reg_rdata_reg[5:0] == $past(slicer_line_select, 2) && reg_rdata_reg[6] == ^reg_rdata_reg[5:0]
		&& reg_rdata_reg[7] == (reg_rdata_reg[5] ^ reg_rdata_reg[3] ^ reg_rdata_reg[1])) else $error("echo wrong");
	unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h80 || reg_addr > 8'h85)
		|=> reg_rdata_reg == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_reg)) else $error("read data moved");
	source_read_a: assert property (reg_rd && reg_addr == 8'h82
		|=> reg_rdata_reg[4:3] == $past({disc_player_source_seen, tape_source_seen}, 2))
		else $error("source flags read wrong");
	irq_raise_a: assert property ($changed(horiz_pll_locked) |-> ##[1:4] irq_reg)
		else $error("no interrupt on lock change");
endmodule
bind vdsr_status vdsr_status_monitor #(.FULL_LAYER_CUT(FULL_LAYER_CUT), .METAL_FIX_CUT(METAL_FIX_CUT))
	vdsr_status_monitor_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
	.vert_sync_captured(vert_sync_captured), .horiz_pll_locked(horiz_pll_locked),
	.output_pll_locked(output_pll_locked), .field_rate_is_fifty(field_rate_is_fifty),
	.standard_identified(standard_identified), .identified_standard_code(identified_standard_code),
	.disc_player_source_seen(disc_player_source_seen), .tape_source_seen(tape_source_seen),
	.noise_estimate_value(noise_estimate_value), .slicer_line_select(slicer_line_select), .irq_reg(irq_reg));
`default_nettype wire

// ==== vdsr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module vdsr_host
(
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_rd,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata_reg
);
	initial
	begin
		reg_addr = 8'h00;
		reg_rd = 1'h0;
		reg_wr = 1'h0;
		reg_wdata = 8'h00;
	end
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge clk);
		reg_rd = 1'h0;
		d = reg_rdata_reg;
	endtask
	// ack bits are written as ones, the device clears them itself
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'h1;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vdsr_regs.vh"
module tb;
	// revision value is arbitrary
	localparam logic [7:0] rev_code = 8'h30;
	logic       clk         = 1'h0;
	logic       rst         = 1'h1;
	logic [4:0] lk          = 5'h00;
	logic [2:0] code        = 3'h0;
	logic [1:0] src         = 2'h2;
	logic [7:0] noise       = 8'h5A;
	logic [5:0] sel         = 6'h2B;
	logic [7:0] filt        = 8'hC3;
	logic [7:0] blank_shift = 8'h00;
	logic       hsync_pulse = 1'h0;
	logic       vsync_pulse = 1'h0;
	logic       active_line = 1'h0;
	logic       in_vbi      = 1'h0;
	logic       fast_blank  = 1'h0;
	logic       irq_reg;
	logic       field_parity_reg;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata_reg;
	logic       reg_rd;
	logic       reg_wr;
	int         num_errors  = 0;
	int         checks_done = 0;
	always #2.5 clk = ~clk;
	vdsr_host host_i (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata_reg(reg_rdata_reg));
	vdsr_status #(.FULL_LAYER_CUT(rev_code[7:4]), .METAL_FIX_CUT(rev_code[3:0])) vdsr_status_i (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg),
		.vert_sync_captured(lk[4]), .horiz_pll_locked(lk[3]), .output_pll_locked(lk[2]),
		.field_rate_is_fifty(lk[1]), .standard_identified(lk[0]), .identified_standard_code(code),
		.disc_player_source_seen(src[1]), .tape_source_seen(src[0]), .noise_estimate_value(noise),
		.slicer_line_select(sel), .slicer_filter_value(filt), .hsync_pulse(hsync_pulse), .vsync_pulse(vsync_pulse),
		.active_line(active_line), .in_vbi(in_vbi), .blank_shift_amount(blank_shift), .fast_blank(fast_blank),
		.field_parity_reg(field_parity_reg), .irq_reg(irq_reg));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// 20-clock lines; vsync k clocks into the last line; fb 1 pulses inside active video, 2 outside
	task field(input int n, input int k, input int fb);
		for (int i = 0; i < n; i++)
			for (int j = 0; j < 20; j++)
			begin
				@(negedge clk);
				hsync_pulse = (j == 0);
				vsync_pulse = (i == n - 1 && j == k);
				active_line = (j >= 4 && j < 16);
				in_vbi = (i == 0);
				fast_blank = (i == 1) && (fb == 1 ? (j >= 6 && j < 9) : (fb == 2 && j >= 17));
			end
	endtask
	task t_regs;
		logic [7:0] d;
		host_i.rd(`VDSR_ADDR_SILICON_REVISION, d);
		chk(d, rev_code);
		host_i.wr(`VDSR_ADDR_SILICON_REVISION, 8'hFF);
		host_i.rd(`VDSR_ADDR_SILICON_REVISION, d);
		chk(d, rev_code);
		host_i.rd(8'h86, d);
		chk(d, `VDSR_UNMAPPED_DATA);
		host_i.rd(`VDSR_ADDR_NOISE_ESTIMATE, d);
		chk(d, 8'h5A);
		host_i.rd(`VDSR_ADDR_SLICER_LINE_ID, d);
		chk(d, 8'hAB);
		host_i.rd(`VDSR_ADDR_SLICER_FILTER, d);
		chk(d, 8'hC3);
		host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
		chk(d & 8'h18, 8'h10);
		src = 2'h1;
		host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
		chk(d & 8'h18, 8'h08);
	endtask
	task t_lock;
		logic [7:0] d;
		for (int i = 0; i < 8; i++)
		begin
			lk = {i[0], ~i[0], i[1], i[2], ~i[1]};
			code = i[2:0];
			host_i.rd(`VDSR_ADDR_LOCK_STANDARD, d);
			chk(d & 8'hE0, {lk, code} & 8'hE0);
			chk(d & 8'h10, {lk, code} & 8'h10);
			chk(d & 8'h08, {lk, code} & 8'h08);
			chk(d & 8'h07, {5'h00, code});
		end
	endtask
	task t_lines;
		int         n [8] = '{309, 310, 314, 315, 259, 260, 264, 265};
		logic [7:0] d;
		for (int i = 0; i < 8; i++)
		begin
			lk[1] = (i < 4);
			field(n[i], 10, 0);
			host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
			if (i < 4)
				chk(d & 8'h01, {7'h00, i % 4 == 0 || i % 4 == 3});
			else
				chk(d & 8'h01, {7'h00, i % 4 == 0 || i % 4 == 3});
		end
	endtask
	task t_parity;
		int         ks [6] = '{10, 1, 10, 10, 5, 15};
		logic [7:0] ex [6] = '{8'h00, 8'h20, 8'h20, 8'h00, 8'h80, 8'h80};
		logic [7:0] d;
		for (int i = 0; i < 6; i++)
		begin
			field(3, ks[i], 0);
			host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
			chk(d & 8'h80, ex[i] & 8'h80);
			if (i < 4)
			begin
				chk(d & 8'h20, ex[i] & 8'h20);
				chk({7'h00, field_parity_reg}, {7'h00, ks[i] == 10});
			end
		end
	endtask
	task t_fb;
		logic [7:0] d;
		field(4, 10, 1);
		host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
		chk(d & 8'h06, 8'h06);
		fork
			field(40, 10, 0);
			begin
				repeat (400) @(negedge clk);
				host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
			end
		join
		chk(d & 8'h06, 8'h06);
		field(4, 10, 2);
		host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
		chk(d & 8'h06, 8'h02);
		for (int i = 0; i < 3; i++)
		begin
			blank_shift = (i == 1) ? 8'h10 : 8'h11;
			noise = (i == 2) ? 8'h20 : 8'h1F;
			field(3, 10, 0);
			host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
			chk(d & 8'h46, (i == 0) ? 8'h40 : 8'h00);
		end
	endtask
	task t_irq;
		logic [7:0] d;
		int         i;
		host_i.wr(`VDSR_ADDR_INTERRUPT_ACK_A, 8'hFF);
		host_i.wr(`VDSR_ADDR_INTERRUPT_ACK_B, 8'h03);
		repeat (3) @(negedge clk);
		chk({7'h00, irq_reg}, 8'h00);
		lk[3] = ~lk[3];
		for (i = 0; i < 8 && irq_reg !== 1'h1; i++)
			@(negedge clk);
		chk({7'h00, irq_reg}, 8'h01);
		host_i.rd(`VDSR_ADDR_LOCK_STANDARD, d);
		host_i.rd(`VDSR_ADDR_SOURCE_DETECT, d);
		chk({7'h00, irq_reg}, 8'h01);
		host_i.wr(`VDSR_ADDR_INTERRUPT_ACK_A, 8'h02);
		repeat (3) @(negedge clk);
		chk({7'h00, irq_reg}, 8'h00);
	endtask
	initial
	begin
		repeat (90000) @(posedge clk);
		num_errors++;
		finish_test;
	end
	initial
	begin
		repeat (10) @(negedge clk);
		rst = 1'h0;
		t_regs;
		t_lock;
		t_lines;
		t_parity;
		t_fb;
		t_irq;
		finish_test;
	end
endmodule
`default_nettype wire
